// ---- logic/suvd_consts.vh ----
// Register offsets, field positions, reset values and timing counts of the detector.
`ifndef SUVD_CONSTS_VH
`define SUVD_CONSTS_VH

// Register bus geometry.
`define SUVD_ADDR_W 12
`define SUVD_DATA_W 8
`define SUVD_OFS_FLAGS_LEVEL 12'hfc6
`define SUVD_OFS_MODE_ENABLE 12'hfc7

// Fields of the flags and level register.
`define SUVD_FL_LEVEL_LSB 0
`define SUVD_FL_LEVEL_MSB 1
`define SUVD_FL_LIVE_BIT 2
`define SUVD_FL_STICKY_BIT 3
`define SUVD_FL_FIX4_BIT 4
`define SUVD_FL_FIX5_BIT 5
`define SUVD_FL_UNDEF_BIT 6
`define SUVD_FL_FIX7_BIT 7
`define SUVD_FL_RESET 8'h20

// Threshold codes; only the first one selects a real level.
`define SUVD_LEVEL_4V50 2'h0

// Fields of the mode and enable register.
`define SUVD_ME_ENABLE_BIT 0
`define SUVD_ME_MODE_BIT 1
`define SUVD_ME_SPARE_LSB 2
`define SUVD_ME_SPARE_MSB 5
`define SUVD_ME_RESET 8'h00

// Action select codes.
`define SUVD_MODE_IRQ 1'h0
`define SUVD_MODE_RST 1'h1

// Timing: clock period and warm-up interval after reset release.
`define SUVD_CLK_PERIOD_NS 50
`define SUVD_WARMUP_NS 102400
// Warm-up length in clocks: 102400 ns at 50 ns per clock, sized for the 16-bit counter.
`define SUVD_WARMUP_CYCLES 16'h0800
`define SUVD_WARMUP_CNT_W 16

`endif

// ---- logic/suvd_sync.v ----
// Two-stage synchroniser for the supply comparator output.
`default_nettype none
module suvd_sync (
  input wire i_ref_clk,
  input wire i_rst_b,
  input wire i_async,
  output reg o_sync
);

  reg meta_r;

  // The first stage feeds only the second stage.
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      meta_r <= 1'h0;
      o_sync <= 1'h0;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule // suvd_sync
`default_nettype wire

// ---- logic/suvd_warmup.v ----
// Warm-up sequencer that holds the CPU and peripheral resets after reset release.
`default_nettype none
`include "suvd_consts.vh"
module suvd_warmup #(
  parameter [`SUVD_WARMUP_CNT_W-1:0] WARMUP_CYCLES = `SUVD_WARMUP_CYCLES
) (
  input wire i_ref_clk,
  input wire i_rst_b,
  input wire i_restart,
  output reg o_cpu_rst_b,
  output reg o_periph_rst_b
);

  localparam [2:0] ST_HOLD = 3'h1;
  localparam [2:0] ST_COUNT = 3'h2;
  localparam [2:0] ST_RUN = 3'h4;
  // Counter step at the counter's own width, so no bits are dropped or padded.
  localparam [`SUVD_WARMUP_CNT_W-1:0] CNT_ONE = {{(`SUVD_WARMUP_CNT_W-1){1'b0}}, 1'b1};

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [`SUVD_WARMUP_CNT_W-1:0] cnt_r;
  reg [`SUVD_WARMUP_CNT_W-1:0] cnt_nxt;

  // Next state: the counter starts once reset is gone and stops at the warm-up count minus one.
  always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      ST_HOLD: begin
        cnt_nxt = {`SUVD_WARMUP_CNT_W{1'b0}};
        if (!i_restart) begin
          state_nxt = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (i_restart) begin
          state_nxt = ST_HOLD;
        end else if (cnt_r >= WARMUP_CYCLES - CNT_ONE) begin
          state_nxt = ST_RUN;
        end else begin
          cnt_nxt = cnt_r + CNT_ONE;
        end
      end
      ST_RUN: begin
        if (i_restart) begin
          state_nxt = ST_HOLD;
        end
      end
      default: begin
        state_nxt = ST_HOLD;
      end
    endcase
  end

  // Reset puts the warm-up circuit back to the hold state and holds the CPU.
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      state_r <= ST_HOLD;
      cnt_r <= {`SUVD_WARMUP_CNT_W{1'b0}};
      o_cpu_rst_b <= 1'h0;
      o_periph_rst_b <= 1'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      o_cpu_rst_b <= (state_nxt == ST_RUN);
      o_periph_rst_b <= (state_nxt == ST_RUN);
    end
  end

endmodule // suvd_warmup
`default_nettype wire

// ---- logic/suvd_ctrl.v ----
// Control and status logic around the supply undervoltage comparator.
//
// What this block does
// - Action bit picks interrupt or reset.
// - Disabled detector makes no flag, interrupt, reset.
// - Sticky flag sets on low, holds afterwards.
// - Writing zero clears flag; one does nothing.
// - Detection beats a same-cycle software clear.
// - Live status bit follows comparator, unlatched.
// - Threshold code zero means the 4.50 V level.
// - Only power-on or external reset clears registers.
// - Bit six of first register is read-only.
// - Top two bits of second register read zero.
// - Enable is zero after reset release.
// - Enabling while already low acts at once.
// - Reset mode asserts reset while supply low.
// - Interrupt mode raises request on threshold crossing.
// - In interrupt mode, every comparator transition while enabled raises a request.
// - Warm-up after reset release, then release CPU.
// - Live status leads sticky flag by one cycle.
// - Undervoltage reset lasts while supply stays low.
`default_nettype none
`include "suvd_consts.vh"
module suvd_ctrl #(
  parameter ADDR_W = `SUVD_ADDR_W,
  parameter DATA_W = `SUVD_DATA_W,
  parameter [`SUVD_WARMUP_CNT_W-1:0] WARMUP_CYCLES = `SUVD_WARMUP_CYCLES
) (
  input wire i_ref_clk,
  input wire i_rst_b,
  input wire [ADDR_W-1:0] i_addr,
  input wire [DATA_W-1:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [DATA_W-1:0] o_rdata,
  input wire i_cmp_low,
  output wire [1:0] o_threshold_select,
  output wire o_cmp_enable,
  output reg o_undervoltage_irq,
  output reg o_uv_rst,
  output wire o_cpu_rst_b,
  output wire o_periph_rst_b
);

  // Detection states, one-hot.
  localparam [2:0] ST_OFF = 3'h1;
  localparam [2:0] ST_ABOVE = 3'h2;
  localparam [2:0] ST_BELOW = 3'h4;

  // Stored fields of the flags and level register.
  reg [1:0] threshold_select_r;
  reg sticky_low_supply_flag_r;
  reg sticky_low_supply_flag_nxt;
  reg fix4_r;
  reg fix5_r;
  reg fix7_r;

  // Stored fields of the mode and enable register.
  reg detect_enable_r;
  reg action_select_r;
  reg [3:0] spare_r;

  // Detection path.
  wire cmp_low_s;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg irq_nxt;
  reg uv_rst_nxt;
  wire live_low_supply_status;

  // Bus decode.
  wire sel_flags;
  wire sel_mode;
  wire wr_flags;
  wire wr_mode;
  reg [DATA_W-1:0] rdata_nxt;

  // The raw comparator output is brought onto the clock first.
  suvd_sync u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_async(i_cmp_low),
    .o_sync(cmp_low_s)
  );

  // The warm-up sequencer also restarts after an undervoltage reset ends.
  suvd_warmup #(
    .WARMUP_CYCLES(WARMUP_CYCLES)
  ) u_warmup (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_restart(o_uv_rst),
    .o_cpu_rst_b(o_cpu_rst_b),
    .o_periph_rst_b(o_periph_rst_b)
  );

  // Address decode; accesses to any other address are ignored.
  assign sel_flags = (i_addr == `SUVD_OFS_FLAGS_LEVEL);
  assign sel_mode = (i_addr == `SUVD_OFS_MODE_ENABLE);
  assign wr_flags = i_wr & sel_flags;
  assign wr_mode = i_wr & sel_mode;

  // The comparator sees the chosen level and runs only while enabled.
  assign o_threshold_select = threshold_select_r;
  assign o_cmp_enable = detect_enable_r;

  // Live status shows the synchronised comparison while detection runs.
  assign live_low_supply_status = detect_enable_r & cmp_low_s;

  // Register writes; only the bus reset input returns them to defaults.
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      threshold_select_r <= `SUVD_LEVEL_4V50;
      fix4_r <= 1'h0;
      fix5_r <= 1'h1;
      fix7_r <= 1'h0;
      detect_enable_r <= 1'h0;
      action_select_r <= `SUVD_MODE_IRQ;
      spare_r <= 4'h0;
    end else begin
      if (wr_flags) begin
        threshold_select_r <= i_wdata[`SUVD_FL_LEVEL_MSB:`SUVD_FL_LEVEL_LSB];
        fix4_r <= i_wdata[`SUVD_FL_FIX4_BIT];
        fix5_r <= i_wdata[`SUVD_FL_FIX5_BIT];
        fix7_r <= i_wdata[`SUVD_FL_FIX7_BIT];
      end
      if (wr_mode) begin
        detect_enable_r <= i_wdata[`SUVD_ME_ENABLE_BIT];
        action_select_r <= i_wdata[`SUVD_ME_MODE_BIT];
        spare_r <= i_wdata[`SUVD_ME_SPARE_MSB:`SUVD_ME_SPARE_LSB];
      end
    end
  end

  // Sticky flag: detection sets it, a written zero clears it, detection wins.
  always @* begin
    sticky_low_supply_flag_nxt = sticky_low_supply_flag_r;
    if (wr_flags && !i_wdata[`SUVD_FL_STICKY_BIT]) begin
      sticky_low_supply_flag_nxt = 1'h0;
    end
    if (live_low_supply_status) begin
      sticky_low_supply_flag_nxt = 1'h1;
    end
  end

  // The flag register lags the live status by one clock.
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      sticky_low_supply_flag_r <= 1'h0;
    end else begin
      sticky_low_supply_flag_r <= sticky_low_supply_flag_nxt;
    end
  end

  // Detection state: off, above threshold or below threshold.
  always @* begin
    state_nxt = state_r;
    irq_nxt = 1'h0;
    case (state_r)
      ST_OFF: begin
        if (detect_enable_r) begin
          if (cmp_low_s) begin
            state_nxt = ST_BELOW;
            irq_nxt = (action_select_r == `SUVD_MODE_IRQ);
          end else begin
            state_nxt = ST_ABOVE;
          end
        end
      end
      ST_ABOVE: begin
        if (!detect_enable_r) begin
          state_nxt = ST_OFF;
        end else if (cmp_low_s) begin
          state_nxt = ST_BELOW;
          irq_nxt = (action_select_r == `SUVD_MODE_IRQ);
        end
      end
      ST_BELOW: begin
        if (!detect_enable_r) begin
          state_nxt = ST_OFF;
        end else if (!cmp_low_s) begin
          state_nxt = ST_ABOVE;
          irq_nxt = (action_select_r == `SUVD_MODE_IRQ);
        end
      end
      default: begin
        state_nxt = ST_OFF;
      end
    endcase
  end

  // Reset output follows the low comparison in reset mode, with no latching.
  always @* begin
    uv_rst_nxt = detect_enable_r & cmp_low_s & (action_select_r == `SUVD_MODE_RST);
  end

  // Detection state, interrupt pulse and reset level flip-flops.
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      state_r <= ST_OFF;
      o_undervoltage_irq <= 1'h0;
      o_uv_rst <= 1'h0;
    end else begin
      state_r <= state_nxt;
      o_undervoltage_irq <= irq_nxt;
      o_uv_rst <= uv_rst_nxt;
    end
  end

  // Read mux; undefined bit six and mode bits 7:6 read as zero, fixed bits 4, 5, 7 read back as written.
  always @* begin
    rdata_nxt = {DATA_W{1'b0}};
    if (i_rd && sel_flags) begin
      rdata_nxt[`SUVD_FL_LEVEL_MSB:`SUVD_FL_LEVEL_LSB] = threshold_select_r;
      rdata_nxt[`SUVD_FL_LIVE_BIT] = live_low_supply_status;
      rdata_nxt[`SUVD_FL_STICKY_BIT] = sticky_low_supply_flag_r;
      rdata_nxt[`SUVD_FL_FIX4_BIT] = fix4_r;
      rdata_nxt[`SUVD_FL_FIX5_BIT] = fix5_r;
      rdata_nxt[`SUVD_FL_UNDEF_BIT] = 1'h0;
      rdata_nxt[`SUVD_FL_FIX7_BIT] = fix7_r;
    end else if (i_rd && sel_mode) begin
      rdata_nxt[`SUVD_ME_ENABLE_BIT] = detect_enable_r;
      rdata_nxt[`SUVD_ME_MODE_BIT] = action_select_r;
      rdata_nxt[`SUVD_ME_SPARE_MSB:`SUVD_ME_SPARE_LSB] = spare_r;
      rdata_nxt[7:6] = 2'h0;
    end
  end

  // Read data stand for the one cycle after the read strobe, zero otherwise.
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_rdata <= {DATA_W{1'b0}};
    end else begin
      o_rdata <= rdata_nxt;
    end
  end

endmodule // suvd_ctrl
`default_nettype wire

// ---- dv/suvd_monitor.sv ----
// Port-level timing checker for the undervoltage detector.
`default_nettype none
module suvd_monitor #(
  parameter int WARMUP_CYCLES = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic [11:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_cmp_low,
  input wire logic [1:0] o_threshold_select,
  input wire logic o_cmp_enable,
  input wire logic o_undervoltage_irq,
  input wire logic o_uv_rst,
  input wire logic o_cpu_rst_b,
  input wire logic o_periph_rst_b
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] low_n;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  // Counts warm-up cycles; an undervoltage reset restarts the count.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b || o_cpu_rst_b || o_uv_rst) begin
      low_n <= 16'h0000;
    end else begin
      low_n <= low_n + 16'h0001;
    end
  end
  // A request follows a synchronised crossing or a fresh enable.
  sequence s_cmp_moved;
    $past(i_cmp_low, 3) != $past(i_cmp_low, 4);
  endsequence
  sequence s_just_enabled;
    $past(o_cmp_enable) && !$past(o_cmp_enable, 2);
  endsequence
  a_irq_cause: assert property (o_undervoltage_irq |-> s_cmp_moved or s_just_enabled)
    else $error("request without cause");
  a_irq_pulse: assert property (o_undervoltage_irq |=> !o_undervoltage_irq)
    else $error("request longer than one cycle");
  a_uv_cause: assert property (o_uv_rst |-> $past(o_cmp_enable) && $past(i_cmp_low, 3))
    else $error("reset without low supply");
  // A mode write one cycle earlier may legally end the reset, so it is left out.
  a_uv_hold: assert property (o_uv_rst && o_cmp_enable && $past(i_cmp_low, 2) &&
    !($past(i_wr) && $past(i_addr) == 12'hfc7) |=> o_uv_rst)
    else $error("reset dropped while low");
  a_mode_excl: assert property (o_uv_rst |-> !o_undervoltage_irq)
    else $error("request and reset together");
  a_off_quiet: assert property (!$past(o_cmp_enable) |-> !o_uv_rst && !o_undervoltage_irq)
    else $error("action while disabled");
  a_warm_len: assert property ($rose(o_cpu_rst_b) |->
    low_n >= WARMUP_CYCLES && low_n <= WARMUP_CYCLES + 3)
    else $error("warm-up length wrong");
  a_warm_uv: assert property (o_uv_rst |=> !o_cpu_rst_b)
    else $error("cpu released during reset");
  a_periph_cpu: assert property (o_periph_rst_b == o_cpu_rst_b)
    else $error("peripheral reset differs");
  a_me_top: assert property ($past(i_rd) && $past(i_addr) == 12'hfc7 |-> o_rdata[7:6] == 2'h0)
    else $error("upper bits not zero");
  a_fl_undef: assert property ($past(i_rd) && $past(i_addr) == 12'hfc6 |-> !o_rdata[6])
    else $error("bit six set");
  a_rst_vals: assert property ($rose(i_rst_b) |-> !o_cmp_enable && o_threshold_select == 2'h0)
    else $error("enable set after reset");
endmodule // suvd_monitor
bind suvd_ctrl suvd_monitor #(.WARMUP_CYCLES(WARMUP_CYCLES)) i_mon (.i_ref_clk(i_ref_clk),
  .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_cmp_low(i_cmp_low), .o_threshold_select(o_threshold_select),
  .o_cmp_enable(o_cmp_enable), .o_undervoltage_irq(o_undervoltage_irq), .o_uv_rst(o_uv_rst),
  .o_cpu_rst_b(o_cpu_rst_b), .o_periph_rst_b(o_periph_rst_b));
`default_nettype wire

// ---- dv/suvd_cmp_model.sv ----
// Behavioural supply comparator facing the detector.
`default_nettype none
module suvd_cmp_model (
  input wire logic i_ref_clk,
  input wire logic i_supply_low,
  input wire logic [1:0] i_level,
  output var logic o_cmp_low = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // Only level code 00 has a real threshold, so reserved codes never trip.
  always @(posedge i_ref_clk) begin
    o_cmp_low <= i_supply_low && (i_level == 2'h0);
  end
endmodule // suvd_cmp_model
`default_nettype wire

// ---- dv/suvd_ctrl_tb.sv ----
// Self-checking bench for the undervoltage detector.
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
  $display("ERROR %0t got %h exp %h", $time, (a), (b)); end end
module suvd_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_ref_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [11:0] i_addr = 12'h000;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic supply_low = 1'b0;
  logic cmp_low;
  wire [7:0] o_rdata;
  wire [1:0] lvl;
  wire en, irq, uv_rst, cpu_rst_b, periph_rst_b;
  int num_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int irqs = 0;
  always #25 i_ref_clk = ~i_ref_clk;
  suvd_cmp_model i_cmp (.i_ref_clk(i_ref_clk), .i_supply_low(supply_low), .i_level(lvl),
    .o_cmp_low(cmp_low));
  suvd_ctrl #(.WARMUP_CYCLES(16'h0008)) i_dut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_cmp_low(cmp_low), .o_threshold_select(lvl), .o_cmp_enable(en),
    .o_undervoltage_irq(irq), .o_uv_rst(uv_rst), .o_cpu_rst_b(cpu_rst_b),
    .o_periph_rst_b(periph_rst_b));
  // Inputs change by non-blocking assignment at an edge; a compare made at an edge
  // sees the values that stood in the cycle before it.
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    tick(1);
    i_wr <= 1'b0;
    tick(1);
  endtask
  task automatic chk_rd(input logic [11:0] a, input logic [7:0] e);
    i_rd <= 1'b1;
    i_addr <= a;
    tick(1);
    i_rd <= 1'b0;
    tick(1);
    `CHK(o_rdata, e)
  endtask
  task automatic do_reset();
    i_rst_b <= 1'b0;
    tick(3);
    i_rst_b <= 1'b1;
    tick(1);
  endtask
  task automatic print_verdict();
    if (num_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Counts request pulses and cuts a hang short.
  always @(posedge i_ref_clk) begin
    cyc++;
    if (irq === 1'b1) irqs <= irqs + 1;
    if (cyc == 3000) begin
      num_errors++;
      print_verdict();
    end
  end
  // Main sequence: fixed bits 4, 5, 7 are always written as 0, 1, 0 in the first register.
  initial begin
    do_reset();
    chk_rd(12'hfc6, 8'h20);
    chk_rd(12'hfc7, 8'h00);
    `CHK(cpu_rst_b, 1'b0)
    tick(8);
    `CHK(cpu_rst_b, 1'b1)
    wr(12'hfc5, 8'hff);
    chk_rd(12'hfc5, 8'h00);
    wr(12'hfc6, 8'h20);
    supply_low <= 1'b1;
    tick(6);
    chk_rd(12'hfc6, 8'h20);
    `CHK(irqs, 0)
    wr(12'hfc7, 8'h01);
    tick(4);
    `CHK(irqs, 1)
    chk_rd(12'hfc6, 8'h2c);
    supply_low <= 1'b0;
    tick(6);
    `CHK(irqs, 2)
    chk_rd(12'hfc6, 8'h28);
    wr(12'hfc6, 8'h20);
    chk_rd(12'hfc6, 8'h20);
    wr(12'hfc6, 8'h28);
    chk_rd(12'hfc6, 8'h20);
    supply_low <= 1'b1;
    tick(3);
    chk_rd(12'hfc6, 8'h24);
    tick(1);
    `CHK(irqs, 3)
    wr(12'hfc6, 8'h20);
    chk_rd(12'hfc6, 8'h2c);
    wr(12'hfc7, 8'h03);
    tick(4);
    `CHK(uv_rst, 1'b1)
    `CHK(irqs, 3)
    tick(6);
    `CHK(uv_rst, 1'b1)
    `CHK(cpu_rst_b, 1'b0)
    chk_rd(12'hfc7, 8'h03);
    supply_low <= 1'b0;
    tick(6);
    `CHK(uv_rst, 1'b0)
    tick(12);
    `CHK(cpu_rst_b, 1'b1)
    wr(12'hfc7, 8'hc0);
    chk_rd(12'hfc7, 8'h00);
    supply_low <= 1'b1;
    tick(6);
    `CHK(uv_rst, 1'b0)
    chk_rd(12'hfc6, 8'h28);
    do_reset();
    chk_rd(12'hfc6, 8'h20);
    chk_rd(12'hfc7, 8'h00);
    print_verdict();
  end
endmodule // suvd_ctrl_tb
`default_nettype wire
